/* hdl/rsec_params.svh */
// Constants for the reset entry and exit sequencer: register offsets, field positions, reset values.
// Assumes it is included by bare name from the package and the design file.
`ifndef RSEC_PARAMS_SVH
`define RSEC_PARAMS_SVH
`define RSEC_ADDR_W          4
`define RSEC_OFF_SRC_EN      4'h0
`define RSEC_OFF_MOD_RST     4'h1
`define RSEC_OFF_LOCK        4'h2
`define RSEC_OFF_STATUS      4'h3
`define RSEC_OFF_SLEEP       4'h4
`define RSEC_OFF_CAUSE       4'h5
`define RSEC_LOCK_BIT        0
`define RSEC_SRC_W           7
`define RSEC_SRC_PIN         0
`define RSEC_SRC_VBAT        1
`define RSEC_SRC_POR         6
`define RSEC_MOD_W           5
`define RSEC_SRC_EN_RST      7'h03
`define RSEC_MOD_RST_RST     5'h00
`define RSEC_START_ADDR      32'h0000_0000
`define RSEC_CLK_LPOSC       2'h0
`define RSEC_WDT_LFOSC       1'h0
`define RSEC_PORT_LATCH_RST  1'h1
`define RSEC_HOLD_CYC        8'h04
`define RSEC_APB_KEEP_MASK   8'h03
`endif

/* hdl/rsec_pkg.sv */
// Types shared by the reset entry and exit sequencer.
// Assumes the constants header sits beside it in hdl/.
`include "rsec_params.svh"
package rsec_pkg;
  // Sequencer states, Gray coded along the reset path.
  typedef enum logic [1:0] {
    RSEC_ST_HOLD  = 2'h0,
    RSEC_ST_EXIT  = 2'h1,
    RSEC_ST_RUN   = 2'h3,
    RSEC_ST_SLEEP = 2'h2
  } rsec_state_t;
  // Clock and enable bundle sent to the core and peripherals.
  typedef struct packed {
    logic       flash_clk_en;
    logic       ram_clk_en;
    logic [7:0] apb_clk_en;
    logic [1:0] sys_clk_sel;
    logic       wdt_en;
    logic       wdt_clk_sel;
  } rsec_clk_t;
endpackage

/* hdl/rsec_reset_seq.sv */
// Reset entry and exit sequencer: holds the core, forces pins and clocks, releases to defaults.
// Assumes reset sources arrive synchronous to sys_clk; registers on a plain strobe port.
//
// Behaviour
// RULE_01: Core held from executing during reset.
// RULE_02: Registers default on reset; POR-only bits keep.
// RULE_03: Port pins forced to known state.
// RULE_04: Port latches one, open-drain, on reset.
// RULE_05: Weak pull-ups on during and after reset.
// RULE_06: Interrupts and timers disabled on reset.
// RULE_07: Flash and RAM bus clocks stay enabled.
// RULE_08: APB clocks off except watchdog and crossbar.
// RULE_09: Reset leaves RAM contents untouched.
// RULE_10: Supply monitor or POR reset drives pin low.
// RULE_11: Exit selects low-power oscillator as clock.
// RULE_12: Exit enables watchdog on low-frequency oscillator.
// RULE_13: Exit starts fetching at address zero.
// RULE_14: Lock bit blocks reset-source register writes.
// RULE_15: Sources may reset selected low-power modules.
// RULE_16: Deepest sleep held until enabled reset source.
// RULE_17: Deep-sleep reset sources: pin, supply, comparators, pump, oscillator, wake.
// RULE_18: Lock stays set until next device reset.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`include "rsec_params.svh"
module rsec_reset_seq #(
  parameter int NUM_PORT = 8,   // Port pins under control.
  parameter int NUM_APB  = 8    // Peripheral bus clock enables.
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire logic [`RSEC_SRC_W-1:0]   reset_req,
  input  wire logic                     sleep_enter,
  input  wire logic [`RSEC_ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output      logic [31:0]              reg_rdata,
  output      logic                     core_halt,
  output      logic [31:0]              fetch_addr,
  output      logic                     fetch_addr_load,
  output      logic                     periph_reset,
  output      logic                     por_reset,
  output      logic                     irq_timer_disable,
  output      rsec_pkg::rsec_clk_t      clk_ctrl,
  output      logic [NUM_PORT-1:0]      port_latch,
  output      logic [NUM_PORT-1:0]      port_open_drain,
  output      logic [NUM_PORT-1:0]      port_pullup_en,
  output      logic                     reset_pin_out,
  output      logic                     reset_pin_oe_n,
  output      logic [`RSEC_MOD_W-1:0]   module_reset,
  output      logic                     deep_sleep
);

  ////////////////////////////////////////////////////////////////////////////
  // State and register storage.

  rsec_pkg::rsec_state_t  state_r;        // Sequencer state.
  rsec_pkg::rsec_state_t  state_nxt;      // Next sequencer state.
  logic [7:0]             hold_cnt_r;     // Cycles left in reset hold.
  logic [`RSEC_SRC_W-1:0] src_en_r;       // Enabled reset sources.
  logic [`RSEC_MOD_W-1:0] mod_rst_r;      // Per-module reset routing.
  logic                   lock_r;         // Clock-and-reset lock bit.
  logic [`RSEC_SRC_W-1:0] cause_r;        // Last reset cause, kept across warm resets.
  logic                   por_seen_r;     // Power-on pulse already consumed.
  logic                   por_hold_r;     // Cause of current hold drives reset pin.
  logic [`RSEC_SRC_W-1:0] src_hit;        // Enabled sources requesting reset.
  logic                   warm_rst;       // Warm reset request this cycle.

  // A source only counts in deep sleep when software enabled it; outside sleep
  // the pin and the supply monitor (the reset-value mask) always reset.
  assign src_hit  = reset_req & (state_r == rsec_pkg::RSEC_ST_SLEEP ? src_en_r :
                    src_en_r | `RSEC_SRC_EN_RST); // [RULE_16] [RULE_17]
  assign warm_rst = |src_hit;

  // Address match used by the write decode; the read decode uses a case on reg_addr.
  function automatic logic hit(input logic [`RSEC_ADDR_W-1:0] a, input logic [`RSEC_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: hold, exit, run, deepest sleep.

  // Next state: any enabled source returns to hold; hold lasts a fixed count after the last request.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      rsec_pkg::RSEC_ST_HOLD: begin
        if (hold_cnt_r == 8'h00 && !warm_rst) begin
          state_nxt = rsec_pkg::RSEC_ST_EXIT;
        end
      end
      rsec_pkg::RSEC_ST_EXIT: begin
        state_nxt = warm_rst ? rsec_pkg::RSEC_ST_HOLD : rsec_pkg::RSEC_ST_RUN;
      end
      rsec_pkg::RSEC_ST_RUN: begin
        if (warm_rst) begin
          state_nxt = rsec_pkg::RSEC_ST_HOLD;
        end else if (sleep_enter) begin
          state_nxt = rsec_pkg::RSEC_ST_SLEEP;
        end
      end
      rsec_pkg::RSEC_ST_SLEEP: begin
        // Nothing but an enabled reset source leaves deepest sleep.
        if (warm_rst) begin
          state_nxt = rsec_pkg::RSEC_ST_HOLD; // [RULE_16]
        end
      end
    endcase
  end

  // State register; reset lands in hold.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= rsec_pkg::RSEC_ST_HOLD;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Hold counter reloads on every new request so the hold is never cut short.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt_r <= `RSEC_HOLD_CYC;
    end else if (warm_rst) begin
      hold_cnt_r <= `RSEC_HOLD_CYC;
    end else if (state_r == rsec_pkg::RSEC_ST_HOLD && hold_cnt_r != 8'h00) begin
      hold_cnt_r <= hold_cnt_r - 8'h01;
    end
  end

  // Track whether this hold came from supply monitor or power-on.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      por_hold_r <= 1'b1;
      por_seen_r <= 1'b0;
    end else begin
      por_seen_r <= 1'b1;
      if (src_hit[`RSEC_SRC_VBAT] || src_hit[`RSEC_SRC_POR]) begin
        por_hold_r <= 1'b1; // [RULE_10]
      end else if (warm_rst) begin
        por_hold_r <= 1'b0;
      end else if (state_r != rsec_pkg::RSEC_ST_HOLD) begin
        por_hold_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers.

  // Reset-source registers reload on any reset, but only accept writes while unlocked.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_en_r  <= `RSEC_SRC_EN_RST;
      mod_rst_r <= `RSEC_MOD_RST_RST;
    end else if (warm_rst) begin
      src_en_r  <= `RSEC_SRC_EN_RST; // [RULE_02]
      mod_rst_r <= `RSEC_MOD_RST_RST;
    end else if (reg_wr && !lock_r) begin // [RULE_14]
      if (hit(reg_addr, `RSEC_OFF_SRC_EN)) begin
        src_en_r <= reg_wdata[`RSEC_SRC_W-1:0];
      end
      if (hit(reg_addr, `RSEC_OFF_MOD_RST)) begin
        mod_rst_r <= reg_wdata[`RSEC_MOD_W-1:0];
      end
    end
  end

  // Lock bit is sticky: software may set it, only a reset clears it.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_r <= 1'b0;
    end else if (warm_rst) begin
      lock_r <= 1'b0; // [RULE_18]
    end else if (reg_wr && hit(reg_addr, `RSEC_OFF_LOCK) && reg_wdata[`RSEC_LOCK_BIT]) begin
      lock_r <= 1'b1; // [RULE_14]
    end
  end

  // Cause log is a power-on-only register: warm resets overwrite it with the sources seen, only rst_n clears it.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_r <= '0;
    end else if (warm_rst) begin
      cause_r <= src_hit; // [RULE_02]
    end
  end

  // Read data stand one cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `RSEC_OFF_SRC_EN:  reg_rdata <= {{(32-`RSEC_SRC_W){1'b0}}, src_en_r};
        `RSEC_OFF_MOD_RST: reg_rdata <= {{(32-`RSEC_MOD_W){1'b0}}, mod_rst_r};
        `RSEC_OFF_LOCK:    reg_rdata <= {31'h0000_0000, lock_r};
        `RSEC_OFF_STATUS:  reg_rdata <= {30'h0000_0000, state_r};
        `RSEC_OFF_SLEEP:   reg_rdata <= {31'h0000_0000, state_r == rsec_pkg::RSEC_ST_SLEEP};
        `RSEC_OFF_CAUSE:   reg_rdata <= {{(32-`RSEC_SRC_W){1'b0}}, cause_r};
        default:           reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to the core, pins and peripherals, all registered.

  // Core, interrupt and start-address outputs. RAM has no reset path here.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_halt         <= 1'b1;
      irq_timer_disable <= 1'b1;
      periph_reset      <= 1'b1;
      por_reset         <= 1'b1;
      fetch_addr        <= `RSEC_START_ADDR;
      fetch_addr_load   <= 1'b0;
      deep_sleep        <= 1'b0;
    end else begin
      core_halt         <= state_nxt == rsec_pkg::RSEC_ST_HOLD; // [RULE_01]
      irq_timer_disable <= state_nxt == rsec_pkg::RSEC_ST_HOLD; // [RULE_06]
      periph_reset      <= state_nxt == rsec_pkg::RSEC_ST_HOLD; // [RULE_02] [RULE_09]
      por_reset         <= !por_seen_r;
      fetch_addr        <= `RSEC_START_ADDR; // [RULE_13]
      // A request that lands in exit sends the sequencer back to hold, so no load then.
      fetch_addr_load   <= state_r == rsec_pkg::RSEC_ST_EXIT &&
                           state_nxt == rsec_pkg::RSEC_ST_RUN; // [RULE_13]
      deep_sleep        <= state_nxt == rsec_pkg::RSEC_ST_SLEEP; // [RULE_16]
    end
  end

  // Clock controls: reset values are also the exit defaults.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_ctrl <= '{1'b1, 1'b1, `RSEC_APB_KEEP_MASK, `RSEC_CLK_LPOSC, 1'b1, `RSEC_WDT_LFOSC};
    end else if (state_nxt == rsec_pkg::RSEC_ST_HOLD) begin
      clk_ctrl.flash_clk_en <= 1'b1;                 // [RULE_07]
      clk_ctrl.ram_clk_en   <= 1'b1;                 // [RULE_07]
      clk_ctrl.apb_clk_en   <= `RSEC_APB_KEEP_MASK;  // [RULE_08]
      clk_ctrl.sys_clk_sel  <= `RSEC_CLK_LPOSC;      // [RULE_11]
      clk_ctrl.wdt_en       <= 1'b1;                 // [RULE_12]
      clk_ctrl.wdt_clk_sel  <= `RSEC_WDT_LFOSC;      // [RULE_12]
    end
  end

  // Pins: latch one, open-drain, pull-ups on; software owns them after exit.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_latch      <= {NUM_PORT{`RSEC_PORT_LATCH_RST}};
      port_open_drain <= '1;
      port_pullup_en  <= '1;
    end else if (state_nxt == rsec_pkg::RSEC_ST_HOLD) begin
      port_latch      <= {NUM_PORT{`RSEC_PORT_LATCH_RST}}; // [RULE_03] [RULE_04]
      port_open_drain <= '1;                              // [RULE_04]
      port_pullup_en  <= '1;                              // [RULE_05]
    end
  end

  // Reset pin is open drain: drive low (enable low) during supply or power-on hold.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_pin_out  <= 1'b0;
      reset_pin_oe_n <= 1'b0;
    end else begin
      reset_pin_out  <= 1'b0;
      reset_pin_oe_n <= !(state_nxt == rsec_pkg::RSEC_ST_HOLD &&
                          (por_hold_r || src_hit[`RSEC_SRC_VBAT] || src_hit[`RSEC_SRC_POR])); // [RULE_10]
    end
  end

  // Routed module resets pulse with a warm reset for the selected modules.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      module_reset <= '1;
    end else begin
      module_reset <= warm_rst ? mod_rst_r : '0; // [RULE_15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_core_halt_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_01]
    warm_rst |=> core_halt) else $error("core not halted after reset request");
  a_lock_blocks_wr: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_14]
    (lock_r && !warm_rst) |=> $stable(src_en_r)) else $error("locked source register changed");
  a_lock_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_18]
    (lock_r && !warm_rst) |=> lock_r) else $error("lock bit cleared without reset");
  a_exit_fetch_zero: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_13]
    fetch_addr_load |-> (fetch_addr == 32'h0000_0000 && !core_halt)) else $error("bad start address");
  a_apb_gated: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_08]
    core_halt |-> (clk_ctrl.apb_clk_en == 8'h03 && clk_ctrl.flash_clk_en)) else $error("clocks wrong in reset");
  a_pin_low_vbat: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_10]
    src_hit[`RSEC_SRC_VBAT] |=> !reset_pin_oe_n [*4]) else $error("reset pin not driven low");
  a_sleep_stays: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_16]
    (deep_sleep && !warm_rst) |=> deep_sleep) else $error("left deep sleep without reset");
  a_pins_forced: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_04]
    core_halt |-> (&port_latch && &port_open_drain && &port_pullup_en)) else $error("pins not forced");
  a_hold_length: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_06]
    (warm_rst ##1 !warm_rst [*5]) |-> irq_timer_disable) else $error("hold released early");

endmodule // rsec_reset_seq

/* verification/rsec_core_model.sv */
// Core-side model for the reset sequencer: a processor that fetches only once it is released.
// Assumes it shares sys_clk and rst_n with the sequencer and sees its outputs directly.
`timescale 1ns/1ns
module rsec_core_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        core_halt,
  input  wire logic [31:0] fetch_addr,
  input  wire logic        fetch_addr_load,
  input  wire logic        deep_sleep,
  input  wire logic        sleep_req,
  output      logic        sleep_enter,
  output      logic        running,
  output      logic [31:0] start_pc
);
  //////////////////////////////////////////////////////////////////////////////
  // Execution state. A halt wipes the captured address so a missed load shows up.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      running  <= 1'b0;
      start_pc <= 32'hFFFF_FFFF;
    end else if (core_halt) begin
      running  <= 1'b0;
      start_pc <= 32'hFFFF_FFFF;
    end else if (fetch_addr_load) begin
      running  <= 1'b1;
      start_pc <= fetch_addr;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Sleep requests come only from running code and last one cycle.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_enter <= 1'b0;
    end else begin
      sleep_enter <= sleep_req && running && !deep_sleep;
    end
  end
endmodule // rsec_core_model

/* verification/rsec_reset_seq_tb_top.sv */
// Testbench for the reset sequencer: power-on, register lock, warm resets and sleep wake-ups.
// Assumes the package, the sequencer and the core model are compiled first; one 125 MHz clock.
`timescale 1ns/1ns
`include "rsec_params.svh"
module rsec_reset_seq_tb_top;
  logic                   sys_clk   = 1'b0;  // Bench clock, 8 ns period.
  logic                   rst_n     = 1'b0;  // Power-on reset, active low.
  logic [`RSEC_SRC_W-1:0] reset_req = '0;    // Reset source requests.
  logic [3:0]             reg_addr  = '0;    // Register word index.
  logic [31:0]            reg_wdata = '0;    // Register write data.
  logic                   reg_wr    = 1'b0;  // Write strobe.
  logic                   reg_rd    = 1'b0;  // Read strobe.
  logic                   sleep_req = 1'b0;  // Asks the core model to request sleep.
  logic [31:0]            reg_rdata, fetch_addr, start_pc, d;
  logic                   core_halt, fetch_addr_load, periph_reset, por_reset, irq_timer_disable;
  logic                   reset_pin_out, reset_pin_oe_n, deep_sleep, sleep_enter, running;
  logic [7:0]             port_latch, port_open_drain, port_pullup_en;
  logic [4:0]             module_reset, m;
  rsec_pkg::rsec_clk_t    clk_ctrl;
  int                     failures = 0;      // Mismatch count.
  int                     n_checks = 0;      // Comparison count.
  int                     seed;              // Random seed.
  always #4 sys_clk = ~sys_clk;
  rsec_reset_seq i_rsec_reset_seq (.sys_clk(sys_clk), .rst_n(rst_n), .reset_req(reset_req),
    .sleep_enter(sleep_enter), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_halt(core_halt), .fetch_addr(fetch_addr),
    .fetch_addr_load(fetch_addr_load), .periph_reset(periph_reset), .por_reset(por_reset),
    .irq_timer_disable(irq_timer_disable), .clk_ctrl(clk_ctrl), .port_latch(port_latch),
    .port_open_drain(port_open_drain), .port_pullup_en(port_pullup_en), .reset_pin_out(reset_pin_out),
    .reset_pin_oe_n(reset_pin_oe_n), .module_reset(module_reset), .deep_sleep(deep_sleep));
  rsec_core_model i_rsec_core_model (.sys_clk(sys_clk), .rst_n(rst_n), .core_halt(core_halt),
    .fetch_addr(fetch_addr), .fetch_addr_load(fetch_addr_load), .deep_sleep(deep_sleep),
    .sleep_req(sleep_req), .sleep_enter(sleep_enter), .running(running), .start_pc(start_pc));
  //////////////////////////////////////////////////////////////////////////////
  // Compares one value; the logic type keeps unknowns from passing.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One-cycle register write.
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  // One-cycle register read; data is taken in the cycle after the strobe only.
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Clock bundle forced while held: memories, the two kept bus clocks and the watchdog enable on, rest off.
  function automatic rsec_pkg::rsec_clk_t hold_clk();
    rsec_pkg::rsec_clk_t c;
    c              = '0;
    c.flash_clk_en = 1'b1;
    c.ram_clk_en   = 1'b1;
    c.apb_clk_en   = `RSEC_APB_KEEP_MASK;
    c.wdt_en       = 1'b1;
    return c;
  endfunction
  // Everything that must stand while the device is held in reset.
  task automatic chk_hold(input logic pin_low);
    check(core_halt, 1'b1);
    check(periph_reset, 1'b1);
    check(port_latch, 8'hFF);
    check(port_open_drain, 8'hFF);
    check(port_pullup_en, 8'hFF);
    check(irq_timer_disable, 1'b1);
    check(clk_ctrl, hold_clk());
    check(reset_pin_oe_n, !pin_low);
    check(reset_pin_out, 1'b0);
  endtask
  // Waits for release under a bound, then checks the exit defaults.
  task automatic wait_run();
    for (int k = 0; k < 40 && core_halt !== 1'b0; k++) begin
      @(posedge sys_clk);
      #1;
    end
    check(core_halt, 1'b0);
    check(periph_reset, 1'b0);
    check(irq_timer_disable, 1'b0);
    check(clk_ctrl.sys_clk_sel, 2'h0);
    check({clk_ctrl.wdt_en, clk_ctrl.wdt_clk_sel}, 2'h2);
    check(port_pullup_en, 8'hFF);
    check(reset_pin_oe_n, 1'b1);
    // The start address load follows the exit state, one cycle after the halt drops.
    @(posedge sys_clk);
    #1;
    check(fetch_addr_load, 1'b1);
    check(fetch_addr, 32'h0000_0000);
    @(posedge sys_clk);
    #1;
    check(start_pc, 32'h0000_0000);
    check(running, 1'b1);
  endtask
  // A warm request of one cycle on source i; the pin is driven only for supply or power-on.
  task automatic warm(input int i, input logic [4:0] mods);
    @(posedge sys_clk);
    reset_req[i] <= 1'b1;
    @(posedge sys_clk);
    reset_req[i] <= 1'b0;
    #1;
    chk_hold(i == `RSEC_SRC_VBAT || i == `RSEC_SRC_POR);
    check(module_reset, mods);
    wait_run();
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    seed = 32'hc326319f;
    repeat (20) @(posedge sys_clk);
    #1;
    chk_hold(1'b1);
    check(module_reset, 5'h1F);
    check(por_reset, 1'b1);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    wait_run();
    $display("power-on test done");
    // Reset values, then an unmapped word that must read as zero.
    rd(`RSEC_OFF_SRC_EN);  check(d, 32'h03);
    rd(`RSEC_OFF_MOD_RST); check(d, 32'h00);
    rd(`RSEC_OFF_LOCK);    check(d, 32'h00);
    rd(`RSEC_OFF_STATUS);  check(d, 32'h03);
    rd(4'hF);              check(d, 32'h00);
    $display("register default test done");
    // Lock: later source writes and an unlock attempt are ignored until a warm reset.
    m = 5'($random(seed));
    wr(`RSEC_OFF_MOD_RST, {27'h0, m});
    wr(`RSEC_OFF_LOCK, 32'h1);
    wr(`RSEC_OFF_MOD_RST, {27'h0, ~m});
    wr(`RSEC_OFF_SRC_EN, 32'h7C);
    wr(`RSEC_OFF_LOCK, 32'h0);
    rd(`RSEC_OFF_SRC_EN);  check(d, 32'h03);
    rd(`RSEC_OFF_LOCK);    check(d, 32'h01);
    warm(`RSEC_SRC_VBAT, m);
    rd(`RSEC_OFF_CAUSE);   check(d, 32'h02);
    rd(`RSEC_OFF_LOCK);    check(d, 32'h00);
    $display("lock test done");
    // Each source wakes deepest sleep only when enabled; a disabled one leaves it asleep.
    for (int i = 0; i < `RSEC_SRC_W; i++) begin
      m = 5'($random(seed));
      wr(`RSEC_OFF_SRC_EN, 32'h1 << i);
      wr(`RSEC_OFF_MOD_RST, {27'h0, m});
      @(posedge sys_clk);
      sleep_req <= 1'b1;
      @(posedge sys_clk);
      sleep_req <= 1'b0;
      // The disabled request waits one edge so it is first seen in deepest sleep.
      @(posedge sys_clk);
      reset_req[(i + 1) % `RSEC_SRC_W] <= 1'b1;
      @(posedge sys_clk);
      reset_req <= '0;
      repeat (3) @(posedge sys_clk);
      #1;
      check(deep_sleep, 1'b1);
      rd(`RSEC_OFF_SLEEP);   check(d, 32'h01);
      warm(i, m);
      check(deep_sleep, 1'b0);
      $display("sleep wake test done for source %0d", i);
    end
    results();
  end
  // Watchdog: the whole sequence needs well under 2000 cycles.
  initial begin
    #(8 * 4000);
    failures++;
    results();
  end
endmodule // rsec_reset_seq_tb_top
